// ==== core/pcs_pkg.sv ====
// shared types and constants for the fast ethernet coding block
package pcs_pkg;

  localparam int          CLK_MHZ            = 40;
  localparam int          LINE_MHZ           = 125;
  localparam logic [10:0] SCR_SEED           = 11'h7FF;
  localparam int          SCR_PERIOD         = 2047;
  localparam logic [4:0]  DSCR_LOCK_ONES     = 5'h1E;
  localparam logic [6:0]  FEF_ONES           = 7'h54;
  localparam logic [2:0]  BIT_CNT_LAST       = 3'h4;
  localparam logic [2:0]  BIT_CNT_RST        = 3'h0;
  localparam logic [4:0]  SYM_IDLE           = 5'h1F;
  localparam logic [4:0]  SYM_J              = 5'h18;
  localparam logic [4:0]  SYM_K              = 5'h11;
  localparam logic [4:0]  SYM_T              = 5'h0D;
  localparam logic [4:0]  SYM_R              = 5'h07;
  localparam logic [1:0]  MLT_ZERO_RST       = 2'h0;

  // decoded signal-detect levels
  typedef enum logic [1:0] {
    SD_NONE     = 2'b00,
    SD_NO_LIGHT = 2'b01,
    SD_LIGHT    = 2'b11
  } sd_e;

  // mlt3 line level, two bits: 00 zero, 01 plus, 11 minus
  typedef enum logic [1:0] {
    MLT_ZERO  = 2'b00,
    MLT_PLUS  = 2'b01,
    MLT_MINUS = 2'b11
  } mlt_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SSD  = 2'b01,
    TX_DATA = 2'b11,
    TX_ESD  = 2'b10
  } txst_e;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mii_s;

  typedef struct packed {
    logic       line_bit;
    mlt_e       line_mlt;
  } line_s;

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = SYM_IDLE;
    case (n)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      default: s = 5'h1D;
    endcase
    return s;
  endfunction

  function automatic logic [4:0] dec5b4b(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h10;
    case (s)
      5'h1E: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0A: r = 5'h04;
      5'h0B: r = 5'h05;
      5'h0E: r = 5'h06;
      5'h0F: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0A;
      5'h17: r = 5'h0B;
      5'h1A: r = 5'h0C;
      5'h1B: r = 5'h0D;
      5'h1C: r = 5'h0E;
      5'h1D: r = 5'h0F;
      default: r = 5'h10;
    endcase
    return r;
  endfunction

endpackage

// ==== core/skid_buffer.sv ====
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module skid_buffer
  import pcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire mii_s in_data,
  input  wire logic in_valid,
  output logic      in_ready,
  output mii_s      out_data,
  output logic      out_valid,
  input  wire logic out_ready
);

  typedef struct packed {
    mii_s [1:0] mem;
    logic       wp;
    logic       rp;
    logic [1:0] cnt;
    logic       rdy;
  } st_s;

  st_s s_q, s_d;
  logic push, pop;

  always_comb begin
    // ready is a flop so the port carries no logic; push follows it exactly
    push = in_valid && s_q.rdy;
    pop  = out_ready && (s_q.cnt != 2'h0);
    s_d  = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    s_d.rdy = (s_d.cnt != 2'h2);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.rdy;
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rp];

endmodule

// ==== core/pcs_coding.sv ====
// fast ethernet line coding for copper and fiber port
// Operation
// - copper transmit runs 4b5b, serialize, scramble, nrzi, then mlt3 in that order.
// - mac nibbles are 4b5b coded first, then each symbol becomes a serial bit stream, one bit per line-rate tick.
// - receive undoes mlt3, recovers bits, undoes nrzi, descrambles, deserializes, and decodes.
// - receive timing follows the local line tick, with no timing recovery, and nrzi-to-nrz uses that same tick.
// - transmit scrambling uses an eleven-bit lfsr and is applied in copper mode only.
// - the sequence repeats every 2047 bits and the receiver uses the same sequence.
// - in fiber mode scrambler, descrambler, mlt3 encode and decode are bypassed.
// - in fiber mode auto-negotiation is skipped and pair crossover is off.
// - signal detect is decoded as no fiber, fiber without light, fiber with light.
// - fiber mode without light declares a far-end fault.
// - during a fault, idle gaps carry 84 ones followed by one zero.
// - fault handling is on after reset and either of two control bits disables it.
`timescale 1ns/10ps
module pcs_coding
  import pcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line_tick,
  input  wire mii_s tx_mii,
  input  wire logic tx_valid,
  output logic      tx_ready,
  input  wire logic [1:0] fiber_signal_detect,
  input  wire logic fef_disable_basic,
  input  wire logic fef_disable_ctrl4,
  output logic      tx_line_bit,
  output mlt_e      tx_line_mlt,
  input  wire logic rx_line_bit,
  input  wire mlt_e rx_line_mlt,
  output mii_s      rx_mii,
  output logic      rx_nib_valid,
  output logic      far_end_fault_indication,
  output logic      fiber_mode,
  output logic      autoneg_enable,
  output logic      crossover_enable
);

  typedef struct packed {
    logic [1:0]  sd_m;
    sd_e         sd;
    logic [1:0]  dis_m;
    logic [1:0]  dis;
    logic        tx_ln_m;
    logic        tx_ln;
    mlt_e        rx_m_m;
    mlt_e        rx_m;
    logic        tick_m;
    logic        tick;
    txst_e       txst;
    logic [4:0]  tsym;
    logic [2:0]  tcnt;
    logic [10:0] tlfsr;
    logic        nrzi;
    mlt_e        mlt;
    logic        mlt_up;
    logic [6:0]  fcnt;
    logic        fef_on;
    logic        tx_bit_o;
    mlt_e        tx_mlt_o;
    logic        rx_prev;
    mlt_e        rx_mprev;
    logic [10:0] rlfsr;
    logic [9:0]  rsh;
    logic        rsync;
    logic [2:0]  rcnt;
    mii_s        rx_o;
    logic        rx_v;
    logic        fef_o;
    logic        fib_o;
    logic        an_o;
    logic        xo_o;
    logic        dlock;
    logic [4:0]  dcnt;
  } st_s;

  st_s  s_q, s_d;
  mii_s b_data;
  logic b_valid;
  logic b_ready;

  skid_buffer u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (tx_mii),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (b_data),
    .out_valid (b_valid),
    .out_ready (b_ready)
  );

  logic       fib;
  logic       fef_now;
  logic       sbit;
  logic       cbit;
  logic       rnrz;
  logic       rsc;
  logic [4:0] rdec;
  logic [9:0] rsh_n;
  logic       dmask;

  always_comb begin
    s_d     = s_q;
    // two flops on every detect, disable, line and tick input, stage one read only by stage two
    s_d.sd_m    = fiber_signal_detect;
    s_d.sd      = sd_e'(s_q.sd_m);
    s_d.dis_m   = {fef_disable_ctrl4, fef_disable_basic};
    s_d.dis     = s_q.dis_m;
    s_d.tx_ln_m = rx_line_bit;
    s_d.tx_ln   = s_q.tx_ln_m;
    s_d.rx_m_m  = rx_line_mlt;
    s_d.rx_m    = s_q.rx_m_m;
    s_d.tick_m  = line_tick;
    s_d.tick    = s_q.tick_m;
    fib     = (s_q.sd != SD_NONE);
    fef_now = (s_q.sd == SD_NO_LIGHT) && (s_q.dis == 2'b00);
    s_d.fef_o = fef_now;
    s_d.fib_o = fib;
    s_d.an_o  = ~fib;
    s_d.xo_o  = ~fib;
    b_ready = 1'b0;
    sbit    = 1'b0;
    cbit    = 1'b0;
    dmask   = 1'b0;
    rnrz    = 1'b0;
    rsc     = 1'b0;
    rdec    = 5'h10;
    rsh_n   = s_q.rsh;
    if (s_q.tick) begin
      // serialize current symbol, msb first
      cbit = s_q.tsym[4];
      if (s_q.fef_on && (s_q.txst == TX_IDLE)) begin
        // fault pattern replaces idle, 84 ones then a zero
        cbit = (s_q.fcnt != FEF_ONES);
        s_d.fcnt = (s_q.fcnt == FEF_ONES) ? 7'h00 : s_q.fcnt + 7'h01;
      end else begin
        s_d.fcnt = 7'h00;
      end
      // scrambler x^11+x^9+1
      s_d.tlfsr = {s_q.tlfsr[9:0], s_q.tlfsr[10] ^ s_q.tlfsr[8]};
      sbit      = fib ? cbit : cbit ^ s_q.tlfsr[10];
      s_d.nrzi  = s_q.nrzi ^ sbit;
      s_d.mlt_up = s_q.mlt_up;
      if (sbit && !fib) begin
        // mlt3 steps 0,-,0,+ on each one
        if (s_q.mlt != MLT_ZERO) begin
          s_d.mlt = MLT_ZERO;
        end else begin
          s_d.mlt    = s_q.mlt_up ? MLT_PLUS : MLT_MINUS;
          s_d.mlt_up = ~s_q.mlt_up;
        end
      end
      s_d.tx_bit_o = s_d.nrzi;
      s_d.tx_mlt_o = fib ? MLT_ZERO : s_q.mlt;
      s_d.tsym     = {s_q.tsym[3:0], 1'b1};
      s_d.tcnt     = s_q.tcnt + 3'h1;
      if (s_q.tcnt == BIT_CNT_LAST) begin
        s_d.tcnt = BIT_CNT_RST;
        b_ready  = (s_q.txst == TX_DATA) || (s_q.txst == TX_IDLE);
        case (s_q.txst)
          TX_IDLE: begin
            s_d.tsym = SYM_IDLE;
            if (b_valid && b_data.en) begin
              s_d.tsym = SYM_J;
              s_d.txst = TX_SSD;
              b_ready  = 1'b0;
            end
          end
          TX_SSD: begin
            s_d.tsym = SYM_K;
            s_d.txst = TX_DATA;
          end
          TX_DATA: begin
            if (b_valid && b_data.en) begin
              s_d.tsym = b_data.er ? 5'h04 : enc4b5b(b_data.d);
            end else begin
              s_d.tsym = SYM_T;
              s_d.txst = TX_ESD;
            end
          end
          default: begin
            s_d.tsym = SYM_R;
            s_d.txst = TX_IDLE;
          end
        endcase
      end
      // receive: mlt3 level change gives nrzi one; fiber takes the bit pin
      s_d.rx_mprev = s_q.rx_m;
      s_d.rx_prev  = s_q.tx_ln;
      rnrz = fib ? (s_q.tx_ln ^ s_q.rx_prev)
                 : (s_q.rx_m != s_q.rx_mprev);
      // descrambler holds the last eleven masks, next mask is [10]^[8]
      dmask     = s_q.rlfsr[10] ^ s_q.rlfsr[8];
      rsc       = fib ? rnrz : rnrz ^ dmask;
      s_d.rlfsr = {s_q.rlfsr[9:0], dmask};
      // load from idle ones only until locked, frame zeros would spoil it
      if (fib) begin
        s_d.dlock = 1'b0;
        s_d.dcnt  = 5'h00;
      end else if (!s_q.dlock) begin
        s_d.rlfsr = {s_q.rlfsr[9:0], ~rnrz};
        s_d.dcnt  = rsc ? s_q.dcnt + 5'h01 : 5'h00;
        s_d.dlock = (s_q.dcnt == DSCR_LOCK_ONES);
      end
      rsh_n   = {s_q.rsh[8:0], rsc};
      s_d.rsh = rsh_n;
      s_d.rx_v = 1'b0;
      s_d.rcnt = s_q.rcnt + 3'h1;
      if (!s_q.rsync) begin
        if ((rsh_n == {SYM_J, SYM_K}) && (fib || s_q.dlock)) begin
          s_d.rsync = 1'b1;
          s_d.rcnt  = BIT_CNT_RST;
        end
      end else if (s_q.rcnt == BIT_CNT_LAST) begin
        s_d.rcnt = BIT_CNT_RST;
        rdec     = dec5b4b(rsh_n[4:0]);
        if (rdec[4]) begin
          s_d.rsync   = 1'b0;
          s_d.rx_o.en = 1'b0;
          s_d.rx_o.er = (rsh_n[4:0] != SYM_T);
        end else begin
          s_d.rx_o.en = 1'b1;
          s_d.rx_o.er = 1'b0;
          s_d.rx_o.d  = rdec[3:0];
          s_d.rx_v    = 1'b1;
        end
      end
    end else begin
      s_d.rx_v = 1'b0;
    end
    s_d.fef_on = fef_now;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.tsym  <= SYM_IDLE;
      s_q.tlfsr <= SCR_SEED;
      s_q.rlfsr <= SCR_SEED;
      s_q.an_o  <= 1'b1;
      s_q.xo_o  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_line_bit              = s_q.tx_bit_o;
  assign tx_line_mlt              = s_q.tx_mlt_o;
  assign rx_mii                   = s_q.rx_o;
  assign rx_nib_valid             = s_q.rx_v;
  assign far_end_fault_indication = s_q.fef_o;
  assign fiber_mode               = s_q.fib_o;
  assign autoneg_enable           = s_q.an_o;
  assign crossover_enable         = s_q.xo_o;

endmodule

// ==== dv/pcs_coding_sva.sv ====
// port assertions for the coding block
`timescale 1ns/10ps
module pcs_coding_sva
  import pcs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] fiber_signal_detect,
  input wire logic       fef_disable_basic,
  input wire logic       fef_disable_ctrl4,
  input wire mlt_e       tx_line_mlt,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       far_end_fault_indication,
  input wire logic       fiber_mode,
  input wire logic       autoneg_enable,
  input wire logic       crossover_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_FX_AN: assert property (autoneg_enable == !fiber_mode)
    else $error("autoneg vs mode");
  AST_FX_XO: assert property (crossover_enable == !fiber_mode)
    else $error("crossover vs mode");
  // line level only moves on a tick, so allow one tick of lag
  AST_FX_MLT: assert property (fiber_mode [*8] |-> tx_line_mlt == MLT_ZERO)
    else $error("mlt3 active in fiber");
  AST_MLT_STEP: assert property (
    $past(tx_line_mlt) != MLT_ZERO && tx_line_mlt != MLT_ZERO |-> $stable(tx_line_mlt))
    else $error("mlt3 jumped");
  AST_SD_NONE: assert property ((fiber_signal_detect == SD_NONE) [*6] |=> !fiber_mode)
    else $error("fiber mode without detect");
  AST_SD_FX: assert property (fiber_signal_detect[0] [*6] |=> fiber_mode)
    else $error("fiber mode missing");
  AST_FEF_SET: assert property (
    (fiber_signal_detect == SD_NO_LIGHT && !fef_disable_basic && !fef_disable_ctrl4) [*6]
    |=> far_end_fault_indication) else $error("fault missing");
  AST_FEF_LIGHT: assert property (
    (fiber_signal_detect == SD_LIGHT) [*6] |=> !far_end_fault_indication)
    else $error("fault with light");
  AST_FEF_OFF: assert property (
    (fef_disable_basic || fef_disable_ctrl4) [*6] |=> !far_end_fault_indication)
    else $error("fault while disabled");
  cover property ($rose(far_end_fault_indication));
  cover property ($rose(fiber_mode));
  cover property (tx_valid && !tx_ready);
endmodule
bind pcs_coding pcs_coding_sva chk_u (.clk(clk), .rst(rst),
  .fiber_signal_detect(fiber_signal_detect), .fef_disable_basic(fef_disable_basic),
  .fef_disable_ctrl4(fef_disable_ctrl4), .tx_line_mlt(tx_line_mlt), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .far_end_fault_indication(far_end_fault_indication),
  .fiber_mode(fiber_mode), .autoneg_enable(autoneg_enable),
  .crossover_enable(crossover_enable));

// ==== dv/line_partner.sv ====
// loopback line partner: paces ticks, returns the line, measures runs of ones
`timescale 1ns/10ps
module line_partner
  import pcs_pkg::*;
#(
  parameter int TICK_DIV = 5
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tx_line_bit,
  input  wire mlt_e tx_line_mlt,
  output logic      line_tick,
  output logic      rx_line_bit,
  output mlt_e      rx_line_mlt,
  output int        run_len,
  output int        n_zero
);
  int   div_q;
  int   ones_q;
  logic last_q;
  // a cable looped back is always driven, so no released level to model
  assign rx_line_bit = tx_line_bit;
  assign rx_line_mlt = tx_line_mlt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q     <= 0;
      line_tick <= 1'b0;
      last_q    <= 1'b0;
      ones_q    <= 0;
      run_len   <= 0;
      n_zero    <= 0;
    end else begin
      div_q     <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      line_tick <= (div_q == 0);
      // sampled at the next tick, when the previous bit has settled
      if (line_tick) begin
        last_q <= tx_line_bit;
        if (tx_line_bit != last_q) begin
          ones_q <= ones_q + 1;
        end else begin
          run_len <= ones_q;
          ones_q  <= 0;
          n_zero  <= n_zero + 1;
        end
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the coding block over a loopback line
`timescale 1ns/10ps
module tb_top
  import pcs_pkg::*;
;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic       tx_valid = 1'b0;
  logic       dis_b    = 1'b0;
  logic       dis_c    = 1'b0;
  logic [1:0] sd       = SD_NONE;
  mii_s       tx_mii   = '0;
  mii_s       rx_mii;
  mlt_e       txm, rxm;
  logic       tick, txb, rxb, rdy, rxv, fef, fmode, an, xo;
  int         run_len, n_zero, n_fail = 0, checked = 0, cyc = 0, n_stall = 0;
  logic [3:0] rxq[$];

  always #12.5 clk = ~clk;

  pcs_coding dut_u (.clk(clk), .rst(rst), .line_tick(tick), .tx_mii(tx_mii),
    .tx_valid(tx_valid), .tx_ready(rdy), .fiber_signal_detect(sd),
    .fef_disable_basic(dis_b), .fef_disable_ctrl4(dis_c), .tx_line_bit(txb),
    .tx_line_mlt(txm), .rx_line_bit(rxb), .rx_line_mlt(rxm), .rx_mii(rx_mii),
    .rx_nib_valid(rxv), .far_end_fault_indication(fef), .fiber_mode(fmode),
    .autoneg_enable(an), .crossover_enable(xo));
  line_partner part_u (.clk(clk), .rst(rst), .tx_line_bit(txb), .tx_line_mlt(txm),
    .line_tick(tick), .rx_line_bit(rxb), .rx_line_mlt(rxm), .run_len(run_len),
    .n_zero(n_zero));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxv && rx_mii.en) rxq.push_back(rx_mii.d);
    if (tx_valid && !rdy) n_stall <= n_stall + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s exp %h got %h", what, exp, got);
    end
  endtask

  // detect level is synced, so settle a few cycles before judging
  task automatic set_sd(input logic [1:0] v, input logic b, input logic c);
    sd    <= v;
    dis_b <= b;
    dis_c <= c;
    repeat (8) @(posedge clk);
  endtask

  task automatic send(input logic [5:0] v);
    int w;
    tx_valid <= 1'b1;
    tx_mii   <= v;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (!rdy && w < 500);
  endtask

  task automatic t_reset();
    chk("flags after reset", 8'h06, {4'h0, fmode, an, xo, fef});
  endtask

  task automatic t_modes();
    logic [1:0] v[3];
    logic [3:0] e[3];
    v = '{SD_NONE, SD_NO_LIGHT, SD_LIGHT};
    e = '{4'h6, 4'h9, 4'h8};
    for (int i = 0; i < 3; i++) begin
      set_sd(v[i], 1'b0, 1'b0);
      chk("mode flags", {4'h0, e[i]}, {4'h0, fmode, an, xo, fef});
    end
  endtask

  task automatic t_disable();
    for (int i = 1; i < 4; i++) begin
      set_sd(SD_NO_LIGHT, i[0], i[1]);
      chk("fault disabled", 8'h00, {7'h00, fef});
    end
    set_sd(SD_NO_LIGHT, 1'b0, 1'b0);
    chk("fault enabled", 8'h01, {7'h00, fef});
  endtask

  // first run may be cut short, so judge the run ended by the third zero
  task automatic t_fef_run();
    int n0;
    int w;
    n0 = n_zero;
    w  = 0;
    while (n_zero < n0 + 3 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    chk("ones before zero", 8'h54, run_len[7:0]);
  endtask

  task automatic t_frame(input logic [1:0] v);
    int w;
    int n0;
    set_sd(v, 1'b0, 1'b0);
    repeat (500) @(posedge clk);
    n0 = n_zero;
    repeat (500) @(posedge clk);
    // scrambled copper idle shows zeros on the line, plain fiber idle none
    chk("idle zeros", {7'h00, v == SD_NONE}, {7'h00, n_zero != n0});
    rxq.delete();
    n_stall = 0;
    for (int i = 0; i < 16; i++) send({2'b10, i[3:0]});
    tx_valid <= 1'b0;
    tx_mii   <= '0;
    w = 0;
    while (rxq.size() < 16 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    for (int i = 0; i < 16; i++) chk("rx nibble", i[7:0], {4'h0, rxq[i]});
    chk("tx stalled", 8'h01, {7'h00, n_stall > 0});
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_disable();
    t_fef_run();
    t_frame(SD_NONE);
    t_frame(SD_LIGHT);
    finish_test();
  end
endmodule
